/* File: common/nfhc_pkg.sv */
// Shared constants and types for the NAND flash host command controller.
package nfhc_pkg;
	localparam int CLK_PERIOD_NS = 20;

	// Pin timing figures in nanoseconds, and the derived clock counts.
	localparam int T_WB_NS  = 100;
	localparam int T_WHR_NS = 60;
	localparam int T_WW_NS  = 100;
	localparam logic [7:0] WB_CYC  = 8'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WW_CYC  = 8'((T_WW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Page geometry and address framing.
	localparam logic [12:0] PAGE_BYTES  = 13'h0840;
	localparam logic [2:0]  ADDR_CYCLES = 3'h5;

	// Command bytes.
	localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
	localparam logic [7:0] CMD_READ_START   = 8'h30;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG   = 8'h15;
	localparam logic [7:0] CMD_STATUS       = 8'h70;
	localparam logic [7:0] CMD_RESET        = 8'hff;

	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_STATUS  = 2'h2,
		OP_RESET   = 2'h3
	} nfhc_op_t;

	// Which command byte of the current operation is due next.
	typedef enum logic [1:0] {
		STG_FIRST  = 2'h0,
		STG_SECOND = 2'h1,
		STG_STATUS = 2'h2
	} nfhc_stage_t;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b000_0001,
		ST_PREP  = 7'b000_0010,
		ST_CMD   = 7'b000_0100,
		ST_ADDR  = 7'b000_1000,
		ST_WDATA = 7'b001_0000,
		ST_WAIT  = 7'b010_0000,
		ST_RDATA = 7'b100_0000
	} nfhc_state_t;

	typedef struct packed {
		nfhc_op_t    op;
		logic [11:0] column;
		logic [16:0] row;
		logic [11:0] length;
	} nfhc_req_t;
endpackage

/* File: verilog/nfhc_fifo.sv */
// Write-data FIFO between the user port and the flash data-input phase.
`timescale 1ns/100ps
module nfhc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             ready_reg;
	logic             push;
	logic             pop;

	assign push          = in_valid_in && ready_reg;
	assign pop           = out_ready_in && (count_reg != '0);
	assign count_next    = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready_out  = ready_reg;
	assign out_valid_out = (count_reg != '0);
	assign out_data_out  = mem[rd_ptr_reg];

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b0;
		end else begin
			wr_ptr_reg <= push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
			rd_ptr_reg <= pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
			count_reg  <= count_next;
			ready_reg  <= (count_next != (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end
endmodule

/* File: verilog/nfhc_host.sv */
// Host controller that drives a NAND flash through its command, address and data pins.
//
// Behaviour
// RULE1: Command byte latched on write strobe rise.
// RULE2: Address byte latched on write strobe rise.
// RULE3: Chip enable high while ready gives standby.
// RULE4: Chip enable ignored while device busy.
// RULE5: Read strobe fall outputs byte, advances column.
// RULE6: Write protect low blocks program and erase.
// RULE7: Open-drain ready/busy low during operations.
// RULE8: Address goes in five framed byte cycles.
// RULE9: Upper page bits select block, lower page.
// RULE10: Page 2112 bytes, block 64 pages.
// RULE11: Latch lines decide each bus cycle type.
// RULE12: Strobes stay high while read busy.
// RULE13: Only status and reset accepted while busy.
// RULE14: Read is 00h, address, then 30h.
// RULE15: Column change and cached read commands.
// RULE16: Program input, column redirect, program starts.
// RULE17: Page copy command sequences.
// RULE18: At most column 2111; no bus contention.
// RULE19: End cached program with 10h.
// RULE20: Cached read resets column counter.
// RULE21: Array load finishes within 25 us.
// RULE22: Programming busy typically 300, max 700 us.
// RULE23: Busy durations set by parameters.
// RULE24: Undefined command bytes are ignored.
`timescale 1ns/100ps
module nfhc_host #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic               clock_in,
	input  wire logic               reset_n_in,
	input  wire logic               req_valid_in,
	input  wire nfhc_pkg::nfhc_req_t req_in,
	output logic                    req_ready_out,
	input  wire logic               wdata_valid_in,
	input  wire logic [7:0]         wdata_in,
	output logic                    wdata_ready_out,
	output logic                    rdata_valid_out,
	output logic [7:0]              rdata_out,
	output logic [7:0]              status_out,
	output logic                    done_out,
	output logic                    busy_out,
	output logic                    ce_n_out,
	output logic                    cle_out,
	output logic                    ale_out,
	output logic                    we_n_out,
	output logic                    re_n_out,
	output logic                    wp_n_out,
	output logic [7:0]              io_out,
	output logic                    io_oe_n_out,
	input  wire logic [7:0]         io_in,
	input  wire logic               ready_busy_n_in
);
	import nfhc_pkg::*;

	nfhc_state_t state_reg, state_next;
	nfhc_stage_t stage_reg, stage_next;
	nfhc_req_t   req_reg, req_next;
	logic        ph_reg, ph_next;
	logic        poll_reg, poll_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic [2:0]  addr_idx_reg, addr_idx_next;
	logic [11:0] byte_cnt_reg, byte_cnt_next;
	logic        ready_reg, ready_next;
	logic        rvalid_next, done_next, busy_next;
	logic [7:0]  rdata_next, status_next, io_next;
	logic        ce_n_next, cle_next, ale_next, we_n_next, re_n_next, wp_n_next, oe_n_next;
	logic        fifo_valid;
	logic [7:0]  fifo_data;
	logic        fifo_pop;
	logic [7:0]  cmd_byte;
	logic [7:0]  addr_byte;
	logic [12:0] col_now;
	logic        wdata_end;
	logic [11:0] read_len;

	function automatic logic [7:0] frame_addr(input logic [2:0] idx, input logic [11:0] col,
		input logic [16:0] row);
		case (idx)
			3'h0: frame_addr = col[7:0];
			3'h1: frame_addr = {4'h0, col[11:8]};
			3'h2: frame_addr = row[7:0];
			3'h3: frame_addr = row[15:8];
			default: frame_addr = {7'h00, row[16]};
		endcase
	endfunction

	function automatic logic [7:0] pick_cmd(input nfhc_op_t op, input nfhc_stage_t stg);
		if (stg == STG_STATUS || op == OP_STATUS) begin
			pick_cmd = CMD_STATUS;
		end else if (op == OP_RESET) begin
			pick_cmd = CMD_RESET;
		end else if (op == OP_READ) begin
			pick_cmd = (stg == STG_FIRST) ? CMD_READ_SETUP : CMD_READ_START;
		end else begin
			pick_cmd = (stg == STG_FIRST) ? CMD_PROG_SETUP : CMD_PROG_CONFIRM;
		end
	endfunction

	assign cmd_byte  = pick_cmd(req_reg.op, stage_reg); // see RULE14 see RULE19
	assign addr_byte = frame_addr(addr_idx_reg, req_reg.column, req_reg.row); // see RULE8
	assign col_now   = 13'(req_reg.column) + 13'(byte_cnt_reg);
	// Input stops at the requested length or at the page end, whichever comes first.
	assign wdata_end = (byte_cnt_reg == req_reg.length) || (col_now >= PAGE_BYTES); // see RULE18
	assign fifo_pop  = (state_reg == ST_WDATA) && !ph_reg && !wdata_end && fifo_valid;
	assign read_len  = (req_reg.op == OP_READ) ? req_reg.length : 12'h001;

	nfhc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_wfifo (
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (wdata_valid_in),
		.in_ready_out  (wdata_ready_out),
		.in_data_in    (wdata_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_data)
	);

	always_comb begin
		state_next    = state_reg;
		stage_next    = stage_reg;
		req_next      = req_reg;
		ph_next       = ph_reg;
		poll_next     = poll_reg;
		cnt_next      = cnt_reg;
		addr_idx_next = addr_idx_reg;
		byte_cnt_next = byte_cnt_reg;
		rdata_next    = rdata_out;
		status_next   = status_out;
		io_next       = io_out;
		ce_n_next     = ce_n_out;
		wp_n_next     = wp_n_out;
		cle_next      = 1'b0;
		ale_next      = 1'b0;
		we_n_next     = 1'b1;
		re_n_next     = 1'b1;
		oe_n_next     = 1'b1;
		rvalid_next   = 1'b0;
		done_next     = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_in && ready_reg) begin
					req_next   = req_in;
					stage_next = STG_FIRST;
					cnt_next   = WW_CYC;
					ce_n_next  = 1'b0;
					wp_n_next  = (req_in.op == OP_PROGRAM); // see RULE6
					state_next = ST_PREP;
				end
			end
			ST_PREP: begin
				if (cnt_reg == 8'h00) begin
					ph_next    = 1'b0;
					state_next = ST_CMD;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			ST_CMD: begin
				cle_next  = 1'b1; // see RULE11
				oe_n_next = 1'b0;
				io_next   = cmd_byte;
				if (!ph_reg) begin
					we_n_next = 1'b0;
					ph_next   = 1'b1;
				end else begin
					// The byte is latched on the rising strobe that this step issues at the next clock edge.
					ph_next = 1'b0; // see RULE1
					if (stage_reg == STG_FIRST && (req_reg.op == OP_READ || req_reg.op == OP_PROGRAM)) begin
						addr_idx_next = 3'h0;
						state_next    = ST_ADDR;
					end else begin
						poll_next  = (req_reg.op == OP_RESET) || (stage_reg == STG_SECOND);
						cnt_next   = ((req_reg.op == OP_RESET) || (stage_reg == STG_SECOND)) ? WB_CYC : WHR_CYC;
						state_next = ST_WAIT;
					end
				end
			end
			ST_ADDR: begin
				ale_next  = 1'b1; // see RULE11
				oe_n_next = 1'b0;
				io_next   = addr_byte;
				if (!ph_reg) begin
					we_n_next = 1'b0;
					ph_next   = 1'b1;
				end else begin
					ph_next = 1'b0; // see RULE2
					if (addr_idx_reg == ADDR_CYCLES - 3'h1) begin // see RULE8
						byte_cnt_next = 12'h000;
						stage_next    = STG_SECOND;
						state_next    = (req_reg.op == OP_PROGRAM) ? ST_WDATA : ST_CMD;
					end else begin
						addr_idx_next = addr_idx_reg + 3'h1;
					end
				end
			end
			ST_WDATA: begin
				if (ph_reg) begin
					oe_n_next = 1'b0;
					ph_next   = 1'b0;
				end else if (wdata_end) begin
					// Program is always confirmed with 10h, never left as a cache program.
					state_next = ST_CMD; // see RULE19
				end else if (fifo_valid) begin
					oe_n_next     = 1'b0;
					io_next       = fifo_data;
					we_n_next     = 1'b0;
					ph_next       = 1'b1;
					byte_cnt_next = byte_cnt_reg + 12'h001;
				end
			end
			ST_WAIT: begin
				// Strobes stay high for the whole wait, so nothing is latched while busy.
				if (cnt_reg != 8'h00) begin // see RULE12
					cnt_next = cnt_reg - 8'h01;
				end else if (!poll_reg || ready_busy_n_in) begin // see RULE7 see RULE21 see RULE22
					if (req_reg.op == OP_RESET) begin
						state_next = ST_IDLE;
						ce_n_next  = 1'b1;
						wp_n_next  = 1'b0;
						done_next  = 1'b1;
					end else if (req_reg.op == OP_PROGRAM && stage_reg == STG_SECOND) begin
						stage_next = STG_STATUS;
						ph_next    = 1'b0;
						state_next = ST_CMD;
					end else begin
						byte_cnt_next = 12'h000;
						ph_next       = 1'b0;
						state_next    = ST_RDATA;
					end
				end
			end
			ST_RDATA: begin
				if (ph_reg) begin
					// Data is valid one period after the read strobe fell.
					rdata_next    = io_in; // see RULE5
					status_next   = (req_reg.op == OP_READ) ? status_out : io_in;
					rvalid_next   = (req_reg.op == OP_READ);
					byte_cnt_next = byte_cnt_reg + 12'h001;
					ph_next       = 1'b0;
				end else if (byte_cnt_reg == read_len) begin
					state_next = ST_IDLE;
					ce_n_next  = 1'b1;
					wp_n_next  = 1'b0;
					done_next  = 1'b1;
				end else begin
					re_n_next = 1'b0;
					ph_next   = 1'b1;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	assign ready_next = (state_next == ST_IDLE);
	assign busy_next  = (state_next != ST_IDLE);

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg    <= ST_IDLE;
			stage_reg    <= STG_FIRST;
			req_reg      <= '0;
			ph_reg       <= 1'b0;
			poll_reg     <= 1'b0;
			cnt_reg      <= 8'h00;
			addr_idx_reg <= 3'h0;
			byte_cnt_reg <= 12'h000;
			ready_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			stage_reg    <= stage_next;
			req_reg      <= req_next;
			ph_reg       <= ph_next;
			poll_reg     <= poll_next;
			cnt_reg      <= cnt_next;
			addr_idx_reg <= addr_idx_next;
			byte_cnt_reg <= byte_cnt_next;
			ready_reg    <= ready_next;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_valid_out <= 1'b0;
			rdata_out       <= 8'h00;
			status_out      <= 8'h00;
			done_out        <= 1'b0;
			busy_out        <= 1'b0;
			ce_n_out        <= 1'b1;
			cle_out         <= 1'b0;
			ale_out         <= 1'b0;
			we_n_out        <= 1'b1;
			re_n_out        <= 1'b1;
			wp_n_out        <= 1'b0;
			io_out          <= 8'h00;
			io_oe_n_out     <= 1'b1;
		end else begin
			rdata_valid_out <= rvalid_next;
			rdata_out       <= rdata_next;
			status_out      <= status_next;
			done_out        <= done_next;
			busy_out        <= busy_next;
			ce_n_out        <= ce_n_next;
			cle_out         <= cle_next;
			ale_out         <= ale_next;
			we_n_out        <= we_n_next;
			re_n_out        <= re_n_next;
			wp_n_out        <= wp_n_next;
			io_out          <= io_next;
			io_oe_n_out     <= oe_n_next;
		end
	end

	assign req_ready_out = ready_reg;

	// Helper for assertions: address bytes strobed since the last command byte.
	logic [2:0] addr_run_reg;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_run_reg <= 3'h0;
		end else if (!we_n_out && cle_out) begin
			addr_run_reg <= 3'h0;
		end else if (!we_n_out && ale_out) begin
			addr_run_reg <= addr_run_reg + 3'h1;
		end
	end

	property p_addr_frame;
		@(posedge clock_in) disable iff (!reset_n_in)
		!we_n_out && ale_out |-> (addr_run_reg != 3'h1 || io_out[7:4] == 4'h0)
			&& (addr_run_reg != 3'h4 || io_out[7:1] == 7'h00) && addr_run_reg < 3'h5;
	endproperty
	a_addr_frame: assert property (p_addr_frame) else $error("Address byte framing wrong."); // see RULE8

	property p_cycle_type;
		@(posedge clock_in) disable iff (!reset_n_in)
		(!we_n_out || !re_n_out) |-> !ce_n_out && !(cle_out && ale_out) && (re_n_out || !(cle_out || ale_out));
	endproperty
	a_cycle_type: assert property (p_cycle_type) else $error("Illegal latch line combination."); // see RULE11

	property p_quiet_busy;
		@(posedge clock_in) disable iff (!reset_n_in)
		state_reg == ST_WAIT && !ready_busy_n_in |=> we_n_out && re_n_out && cle_out == 1'b0;
	endproperty
	a_quiet_busy: assert property (p_quiet_busy) else $error("Strobe moved while device busy."); // see RULE12

	property p_read_seq;
		@(posedge clock_in) disable iff (!reset_n_in)
		!we_n_out && cle_out && io_out == CMD_READ_START |-> addr_run_reg == 3'h5 ##1 we_n_out [*2];
	endproperty
	a_read_seq: assert property (p_read_seq) else $error("Read start without five addresses."); // see RULE14

	property p_no_contention;
		@(posedge clock_in) disable iff (!reset_n_in)
		$fell(re_n_out) |-> io_oe_n_out && $past(io_oe_n_out);
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("Bus driven during read."); // see RULE18

	property p_page_limit;
		@(posedge clock_in) disable iff (!reset_n_in)
		!we_n_out && !cle_out && !ale_out |-> col_now <= PAGE_BYTES;
	endproperty
	a_page_limit: assert property (p_page_limit) else $error("Data past column 2111."); // see RULE18

	property p_prog_end;
		@(posedge clock_in) disable iff (!reset_n_in)
		!we_n_out && cle_out && req_reg.op == OP_PROGRAM && stage_reg == STG_SECOND
			|-> io_out == CMD_PROG_CONFIRM && io_out != CMD_CACHE_PROG;
	endproperty
	a_prog_end: assert property (p_prog_end) else $error("Program not confirmed with 10h."); // see RULE19
endmodule

/* File: tb/nfhc_flash_model.sv */
// Behavioural NAND flash device that answers the host controller on its pins.
`timescale 1ns/100ps
module nfhc_flash_model #(
	parameter int READ_CYC = 30,
	parameter int PROG_CYC = 40,
	parameter int RST_CYC  = 12
) (
	input  wire logic       clock_in,
	input  wire logic       ce_n_in,
	input  wire logic       cle_in,
	input  wire logic       ale_in,
	input  wire logic       we_n_in,
	input  wire logic       re_n_in,
	input  wire logic       wp_n_in,
	input  wire logic       io_oe_n_in,
	input  wire logic [7:0] io_in,
	output logic      [7:0] io_out,
	output logic            rb_low_out,
	output int              viol_out
);
	logic [7:0]  mem [logic [28:0]];
	logic [7:0]  pend [logic [11:0]];
	logic [7:0]  mode = 8'h01;
	logic [7:0]  nxt;
	logic [11:0] col = '0;
	logic [11:0] col_ptr = '0;
	logic [16:0] row = '0;
	logic [2:0]  acnt = '0;
	logic        stat_mode = 1'b0;
	logic        fail = 1'b0;
	logic        drive = 1'b0;
	logic        standby = 1'b1;

	initial begin
		io_out = 8'h3c;
		rb_low_out = 1'b0;
		viol_out = 0;
	end

	// Busy lengths are parameters in clock cycles so the run stays short.
	// Ready returns on a falling edge so the host never races it at its sampling edge.
	task automatic go_busy(input int n);
		fork
			begin
				rb_low_out = 1'b1;
				repeat (n) @(negedge clock_in);
				rb_low_out = 1'b0;
			end
		join_none
	endtask

	task automatic command(input logic [7:0] c);
		if (!(c inside {8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h3f, 8'h80, 8'h85, 8'h10, 8'h15, 8'h3a, 8'h8c,
			8'h70, 8'h71, 8'hff})) begin
			return;
		end
		if (rb_low_out && !(c inside {8'h70, 8'h71, 8'hff})) begin
			return;
		end
		stat_mode = (c == 8'h70 || c == 8'h71);
		case (c)
			8'h00, 8'h05, 8'h80, 8'h85, 8'h8c: begin
				acnt = '0;
				mode = c;
				if (c == 8'h80) begin
					pend.delete();
				end
			end
			8'h30, 8'h3a: if (mode == 8'h00) begin
				col_ptr = col;
				mode = 8'h30;
				go_busy(READ_CYC);
			end
			8'he0: col_ptr = (mode == 8'h05) ? col : col_ptr;
			8'h31, 8'h3f: begin
				col_ptr = '0;
				go_busy(READ_CYC);
			end
			8'h10, 8'h15: if (mode inside {8'h80, 8'h85, 8'h8c}) begin
				fail = !wp_n_in;
				if (wp_n_in) begin
					foreach (pend[k]) mem[{row, k}] = pend[k];
				end
				mode = 8'h01;
				go_busy(PROG_CYC);
			end
			8'hff: begin
				mode = 8'h01;
				go_busy(RST_CYC);
			end
			default: ;
		endcase
	endtask

	task automatic address(input logic [7:0] a);
		case (acnt)
			3'h0: col[7:0] = a;
			3'h1: col[11:8] = a[3:0];
			3'h2: row[7:0] = a;
			3'h3: row[15:8] = a;
			default: row[16] = a[0];
		endcase
		if ((acnt == 3'h1 && a[7:4] != 4'h0) || (acnt == 3'h4 && a[7:1] != 7'h00)) begin
			viol_out++;
		end
		acnt++;
		col_ptr = col;
	endtask

	always @(posedge we_n_in) begin
		if (!ce_n_in && cle_in && !ale_in) begin
			command(io_in);
		end else if (!ce_n_in && ale_in && !cle_in) begin
			address(io_in);
		end else if (!ce_n_in && mode inside {8'h80, 8'h85, 8'h8c}) begin
			if (!wp_n_in || col_ptr > 12'h83f) begin
				viol_out++;
			end else begin
				pend[col_ptr] = io_in;
			end
			col_ptr++;
		end
	end

	// Any strobe during a busy phase other than a command write or a status read is the host's fault.
	always @(negedge we_n_in) begin
		if (!ce_n_in && rb_low_out && !cle_in) begin
			viol_out++;
		end
	end

	always @(negedge re_n_in) begin
		if (!ce_n_in && rb_low_out && !stat_mode) begin
			viol_out++;
		end
		if (!ce_n_in && !cle_in && !ale_in) begin
			nxt = mem.exists({row, col_ptr}) ? mem[{row, col_ptr}] : row[7:0] ^ col_ptr[7:0] ^ 8'h5a;
			if (stat_mode) begin
				nxt = {1'b0, !rb_low_out, 5'h00, fail};
			end else begin
				col_ptr++;
			end
			#15;
			io_out = nxt;
			drive = 1'b1;
		end
	end

	// A released bus shows the inverse of its last byte, never a stale copy.
	always @(posedge re_n_in) begin
		#5;
		if (drive) begin
			drive = 1'b0;
			io_out = ~io_out;
		end
	end

	always @(posedge clock_in) begin
		if (drive && !io_oe_n_in) begin
			viol_out++;
		end
	end

	always @(ce_n_in) begin
		standby = ce_n_in && (standby || !rb_low_out);
	end
endmodule

/* File: tb/nfhc_host_test.sv */
// Self-checking testbench for the NAND flash host controller against a device model.
`timescale 1ns/100ps
module nfhc_host_test;
	import nfhc_pkg::*;
	localparam int LIMIT = 3000;
	logic       clock_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic       req_valid_in = 1'b0;
	nfhc_req_t  req_in = '0;
	logic       wdata_valid_in = 1'b0;
	logic [7:0] wdata_in = 8'h00;
	logic       req_ready_out, wdata_ready_out, rdata_valid_out, done_out, busy_out, rb_low;
	logic       ce_n_out, cle_out, ale_out, we_n_out, re_n_out, wp_n_out, io_oe_n_out;
	logic [7:0] rdata_out, status_out, io_out, io_in, dev_io;
	logic [7:0] got [$];
	int         fails = 0;
	int         n_checks = 0;
	int         viol;

	always #10 clock_in = ~clock_in;
	assign io_in = io_oe_n_out ? dev_io : io_out;

	nfhc_host #(.FIFO_DEPTH(8)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .req_ready_out(req_ready_out), .wdata_valid_in(wdata_valid_in), .wdata_in(wdata_in),
		.wdata_ready_out(wdata_ready_out), .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out),
		.status_out(status_out), .done_out(done_out), .busy_out(busy_out), .ce_n_out(ce_n_out),
		.cle_out(cle_out), .ale_out(ale_out), .we_n_out(we_n_out), .re_n_out(re_n_out), .wp_n_out(wp_n_out),
		.io_out(io_out), .io_oe_n_out(io_oe_n_out), .io_in(io_in), .ready_busy_n_in(!rb_low));

	nfhc_flash_model flash (.clock_in(clock_in), .ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
		.we_n_in(we_n_out), .re_n_in(re_n_out), .wp_n_in(wp_n_out), .io_oe_n_in(io_oe_n_out), .io_in(io_in),
		.io_out(dev_io), .rb_low_out(rb_low), .viol_out(viol));

	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang(input string what);
		check(what, 0, 1);
		report_and_stop();
	endtask

	task automatic request(input nfhc_op_t op, input logic [11:0] c, input logic [16:0] r, input logic [11:0] n);
		int i;
		req_in = '{op: op, column: c, row: r, length: n};
		req_valid_in = 1'b1;
		for (i = 0; i < LIMIT && req_ready_out !== 1'b1; i++) @(negedge clock_in);
		if (i == LIMIT) hang("request taken");
		@(negedge clock_in);
		req_valid_in = 1'b0;
	endtask

	task automatic wait_done(input string what);
		int i;
		got.delete();
		for (i = 0; i < LIMIT && done_out !== 1'b1; i++) begin
			@(negedge clock_in);
			if (rdata_valid_out === 1'b1) got.push_back(rdata_out);
			if (busy_out === 1'b1 && req_ready_out !== 1'b0) check("ready while busy", req_ready_out, 0);
			if (we_n_out === 1'b0 && cle_out === 1'b1) check("latch lines", ale_out, 0);
		end
		if (i == LIMIT) hang(what);
		check("ce_n after done", ce_n_out, 1);
	endtask

	// The valid strobe is left high between bytes; the caller lowers it.
	task automatic push(input logic [7:0] v);
		int i;
		wdata_in = v;
		wdata_valid_in = 1'b1;
		for (i = 0; i < LIMIT && wdata_ready_out !== 1'b1; i++) @(negedge clock_in);
		if (i == LIMIT) hang("write data taken");
		@(negedge clock_in);
	endtask

	task automatic t_reset();
		check("pins in reset", {ce_n_out, cle_out, ale_out, we_n_out, re_n_out, wp_n_out, io_oe_n_out,
			req_ready_out, wdata_ready_out}, 9'h134);
		reset_n_in = 1'b1;
		@(negedge clock_in);
		check("ready after reset", {req_ready_out, wdata_ready_out}, 2'h3);
	endtask

	task automatic t_status();
		request(OP_STATUS, 12'h000, 17'h0_0000, 12'h000);
		wait_done("status");
		check("status byte", status_out, 8'h40);
	endtask

	task automatic t_page_end();
		int i;
		for (i = 0; i < 8; i++) push(8'hb0 + 8'(i));
		wdata_valid_in = 1'b0;
		@(negedge clock_in);
		check("fifo full", wdata_ready_out, 0);
		request(OP_PROGRAM, 12'h83c, 17'h0_0ac1, 12'h008);
		wait_done("program at page end");
		check("program status", status_out, 8'h40);
		for (i = 0; i < 4; i++) check("page end byte", flash.mem[{17'h0_0ac1, 12'h83c + 12'(i)}], 8'hb0 + 8'(i));
		check("past page end", flash.mem.exists({17'h0_0ac1, 12'h840}), 0);
		request(OP_PROGRAM, 12'h000, 17'h0_0ac2, 12'h004);
		wait_done("program leftover");
		for (i = 0; i < 4; i++) check("leftover byte", flash.mem[{17'h0_0ac2, 12'(i)}], 8'hb4 + 8'(i));
	endtask

	task automatic t_program();
		int i;
		fork
			begin
				request(OP_PROGRAM, 12'h1fc, 17'h1_0045, 12'h00c);
				wait_done("program");
			end
			begin
				for (i = 0; i < 12; i++) push(8'ha0 + 8'(i));
				wdata_valid_in = 1'b0;
			end
		join
		check("program status", status_out, 8'h40);
		for (i = 0; i < 12; i++) check("stored byte", flash.mem[{17'h1_0045, 12'h1fc + 12'(i)}], 8'ha0 + 8'(i));
		check("beyond length", flash.mem.exists({17'h1_0045, 12'h208}), 0);
	endtask

	task automatic t_read(input logic [11:0] c, input logic [16:0] r, input logic [11:0] n, input logic [7:0] base,
		input logic fresh);
		request(OP_READ, c, r, n);
		wait_done("read");
		check("read count", 32'(got.size()), 32'(n));
		foreach (got[i]) begin
			check("read byte", got[i], fresh ? r[7:0] ^ (c[7:0] + 8'(i)) ^ 8'h5a : base + 8'(i));
		end
	endtask

	task automatic t_reset_op();
		request(OP_RESET, 12'h000, 17'h0_0000, 12'h000);
		wait_done("reset command");
		check("ready after reset command", {rb_low, busy_out}, 2'h0);
	endtask

	initial begin
		repeat (8) @(negedge clock_in);
		t_reset();
		t_status();
		t_page_end();
		t_program();
		t_read(12'h1fc, 17'h1_0045, 12'h00c, 8'ha0, 1'b0);
		t_read(12'h200, 17'h1_0045, 12'h003, 8'ha4, 1'b0);
		t_read(12'h005, 17'h1_ffff, 12'h004, 8'h00, 1'b1);
		t_read(12'h000, 17'h0_0ac2, 12'h000, 8'h00, 1'b0);
		t_reset_op();
		check("device side faults", viol, 0);
		report_and_stop();
	end
endmodule
